// ---- rtl/cpwm_cfg.svh ----
// register offsets, field positions and reset values of the compare/pwm unit
`ifndef CPWM_CFG_SVH
`define CPWM_CFG_SVH

`define CPWM_OFF_CTRL      8'h00
`define CPWM_OFF_VAL_LO    8'h04
`define CPWM_OFF_VAL_HI    8'h08
`define CPWM_OFF_PERIOD    8'h0c
`define CPWM_OFF_PTCTL     8'h10
`define CPWM_OFF_STATUS    8'h14
`define CPWM_OFF_CFG       8'h18

`define CPWM_CTRL_EN       7
`define CPWM_CTRL_OE       6
`define CPWM_CTRL_OUT      5
`define CPWM_CTRL_FMT      4
`define CPWM_PTCTL_ON      7
`define CPWM_STATUS_FLAG   0
`define CPWM_CFG_ADC_SEL   0
`define CPWM_CFG_WAKE_EN   1

`define CPWM_RST_CTRL      8'h00
`define CPWM_RST_VAL       8'h00
`define CPWM_RST_PERIOD    8'hff
`define CPWM_RST_PTCTL     8'h00

`endif

// ---- rtl/cpwm_pkg.sv ----
// types shared by the compare/pwm unit
package cpwm_pkg;

    typedef enum logic [3:0] {
        CPWM_OFF         = 4'h0,
        CPWM_CMP_TGL_RST = 4'h1,
        CPWM_CMP_TGL     = 4'h2,
        CPWM_CAP_FALL    = 4'h4,
        CPWM_CAP_RISE    = 4'h5,
        CPWM_CMP_SET     = 4'h8,
        CPWM_CMP_CLR     = 4'h9,
        CPWM_CMP_PULSE   = 4'ha,
        CPWM_CMP_TRIG    = 4'hb,
        CPWM_PWM         = 4'hc
    } cpwm_mode_e;

    typedef struct packed {
        logic [7:0]  ctrl;
        logic [7:0]  val_lo;
        logic [7:0]  val_hi;
        logic [7:0]  period;
        logic [7:0]  ptctl;
        logic        flag;
        logic        adc_sel;
        logic        wake_en;
        logic [5:0]  pre;
        logic [1:0]  q;
        logic [7:0]  tmr2;
        logic [9:0]  duty;
        logic        match_d;
        logic        trig_pend;
        logic [1:0]  cap_s;
        logic        cap_d;
        logic        out;
        logic        pin;
        logic        adc_trig;
        logic        tb_rst;
        logic        wake;
        logic        wr_pend;
        logic [2:0]  wr_idx;
        logic        rdy;
        logic [31:0] rdata;
    } cpwm_state_s;

endpackage

// ---- rtl/cpwm_unit.sv ----
// compare/capture/pwm unit with an ahb-lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "cpwm_cfg.svh"

module cpwm_unit
    import cpwm_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic [15:0] tb_count,
    input  wire logic        cap_in,
    output logic             ccp_pin,
    output logic             ccp_int,
    output logic             adc_trig,
    output logic             tb_reset,
    output logic             wake_req,
    output logic             event_flag
);

    cpwm_state_s st_r;
    cpwm_state_s st_nxt;

    // byte offset to register index, 3'h7 when unmapped
    function automatic logic [2:0] reg_idx(input logic [31:0] a);
        case (a[7:0])
            `CPWM_OFF_CTRL:   reg_idx = 3'h0;
            `CPWM_OFF_VAL_LO: reg_idx = 3'h1;
            `CPWM_OFF_VAL_HI: reg_idx = 3'h2;
            `CPWM_OFF_PERIOD: reg_idx = 3'h3;
            `CPWM_OFF_PTCTL:  reg_idx = 3'h4;
            `CPWM_OFF_STATUS: reg_idx = 3'h5;
            `CPWM_OFF_CFG:    reg_idx = 3'h6;
            default:          reg_idx = 3'h7;
        endcase
    endfunction

    // prescaler terminal count for 1, 4, 16, 64
    function automatic logic [5:0] pre_lim(input logic [1:0] ck);
        case (ck)
            2'h0:    pre_lim = 6'h00;
            2'h1:    pre_lim = 6'h03;
            2'h2:    pre_lim = 6'h0f;
            default: pre_lim = 6'h3f;
        endcase
    endfunction

    // register read value
    function automatic logic [31:0] rd_val(input cpwm_state_s s,
                                           input logic [2:0] i);
        case (i)
            3'h0:    rd_val = {24'h000000, s.ctrl};
            3'h1:    rd_val = {24'h000000, s.val_lo};
            3'h2:    rd_val = {24'h000000, s.val_hi};
            3'h3:    rd_val = {24'h000000, s.period};
            3'h4:    rd_val = {24'h000000, s.ptctl};
            3'h5:    rd_val = {31'h00000000, s.flag};
            3'h6:    rd_val = {30'h00000000, s.wake_en, s.adc_sel};
            default: rd_val = 32'h00000000;
        endcase
    endfunction

    logic       en;
    logic [3:0] mode;
    logic       is_pwm;
    logic       match;
    logic       cmp_evt;
    logic       cap_evt;
    logic       tick;
    logic       start;
    logic [9:0] dec;
    logic [9:0] cnt;
    logic       take;
    logic [2:0] a_idx;

    always_comb begin
        st_nxt   = st_r;
        en       = st_r.ctrl[`CPWM_CTRL_EN];
        mode     = st_r.ctrl[3:0];
        is_pwm   = (mode[3:2] == 2'b11);
        match    = (tb_count == {st_r.val_hi, st_r.val_lo});
        cmp_evt  = 1'b0;
        cap_evt  = 1'b0;
        tick     = 1'b0;
        start    = 1'b0;
        take     = hsel & htrans[1] & hready;
        a_idx    = reg_idx(haddr);
        // right aligned: high[1:0]:low, left aligned: low:high[7:6]
        if (st_r.ctrl[`CPWM_CTRL_FMT]) begin
            dec = {st_r.val_lo, st_r.val_hi[7:6]};
        end else begin
            dec = {st_r.val_hi[1:0], st_r.val_lo};
        end
        st_nxt.adc_trig  = 1'b0;
        st_nxt.tb_rst    = 1'b0;
        st_nxt.trig_pend = 1'b0;
        st_nxt.rdy       = 1'b1;
        st_nxt.cap_s     = {st_r.cap_s[0], cap_in};
        st_nxt.cap_d     = st_r.cap_s[1];
        st_nxt.match_d   = match;

        // data phase of a write
        if (st_r.wr_pend) begin
            case (st_r.wr_idx)
                3'h0: st_nxt.ctrl = {hwdata[7:6], st_r.ctrl[5], hwdata[4:0]};
                3'h1: st_nxt.val_lo = hwdata[7:0];
                3'h2: st_nxt.val_hi = hwdata[7:0];
                3'h3: st_nxt.period = hwdata[7:0];
                3'h4: st_nxt.ptctl  = hwdata[7:0];
                3'h5: begin
                    if (hwdata[`CPWM_STATUS_FLAG]) begin
                        st_nxt.flag = 1'b0;
                    end
                end
                3'h6: begin
                    st_nxt.adc_sel = hwdata[`CPWM_CFG_ADC_SEL];
                    st_nxt.wake_en = hwdata[`CPWM_CFG_WAKE_EN];
                end
                default: begin
                end
            endcase
        end

        // period timer with prescaler and two step bits
        if (st_r.ptctl[`CPWM_PTCTL_ON]) begin
            if (st_r.pre >= pre_lim(st_r.ptctl[1:0])) begin
                st_nxt.pre = 6'h00;
                tick       = 1'b1;
            end else begin
                st_nxt.pre = st_r.pre + 6'h01;
            end
        end
        if (tick) begin
            st_nxt.q = st_r.q + 2'h1;
            if (st_r.q == 2'h3) begin
                if (st_r.tmr2 == st_r.period) begin
                    st_nxt.tmr2 = 8'h00;
                    start       = 1'b1;
                end else begin
                    st_nxt.tmr2 = st_r.tmr2 + 8'h01;
                end
            end
        end

        // duty compared against the count the next cycle will show
        cnt = {st_nxt.tmr2, st_nxt.q};

        if (en && is_pwm) begin
            // duty in quarter steps of the period count
            if (start) begin
                st_nxt.duty = dec;
                st_nxt.out  = (dec != 10'h000);
                st_nxt.flag = 1'b1;
            end else if (cnt >= st_r.duty) begin
                st_nxt.out = 1'b0;
            end
        end else if (en && mode[3:1] == 3'b010) begin
            // capture on the chosen edge of the synchronised input
            if (mode[0]) begin
                cap_evt = st_r.cap_s[1] & ~st_r.cap_d;
            end else begin
                cap_evt = ~st_r.cap_s[1] & st_r.cap_d;
            end
            if (cap_evt) begin
                st_nxt.val_lo = tb_count[7:0];
                st_nxt.val_hi = tb_count[15:8];
                st_nxt.flag   = 1'b1;
            end
        end else if (en && mode != 4'h0) begin
            cmp_evt = match & ~st_r.match_d;
            if (mode == CPWM_CMP_PULSE) begin
                st_nxt.out = 1'b0;
            end
            if (cmp_evt) begin
                st_nxt.flag     = 1'b1;
                st_nxt.adc_trig = st_r.adc_sel;
                case (mode)
                    CPWM_CMP_TGL_RST: begin
                        st_nxt.out       = ~st_r.out;
                        st_nxt.trig_pend = 1'b1;
                    end
                    CPWM_CMP_TGL:   st_nxt.out = ~st_r.out;
                    CPWM_CMP_SET:   st_nxt.out = 1'b1;
                    CPWM_CMP_CLR:   st_nxt.out = 1'b0;
                    CPWM_CMP_PULSE: st_nxt.out = 1'b1;
                    CPWM_CMP_TRIG:  st_nxt.trig_pend = 1'b1;
                    default: begin
                    end
                endcase
            end
        end

        // clearing the whole control word wins over an event of this cycle
        if (st_r.wr_pend && st_r.wr_idx == 3'h0 && hwdata[7:0] == 8'h00) begin
            st_nxt.out = 1'b0;
        end

        // timebase reset one edge after the trigger, only if still matching
        st_nxt.tb_rst = st_r.trig_pend & match;

        st_nxt.ctrl[`CPWM_CTRL_OUT] = st_nxt.out;
        st_nxt.pin  = st_nxt.out & st_nxt.ctrl[`CPWM_CTRL_OE];
        st_nxt.wake = st_nxt.flag & st_nxt.wake_en;

        // address phase; reads see writes of the same cycle
        st_nxt.wr_pend = take & hwrite;
        st_nxt.wr_idx  = a_idx;
        if (take && !hwrite) begin
            st_nxt.rdata = rd_val(st_nxt, a_idx);
        end else begin
            st_nxt.rdata = 32'h00000000;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st_r         <= '0;
            st_r.ctrl    <= `CPWM_RST_CTRL;
            st_r.val_lo  <= `CPWM_RST_VAL;
            st_r.val_hi  <= `CPWM_RST_VAL;
            st_r.period  <= `CPWM_RST_PERIOD;
            st_r.ptctl   <= `CPWM_RST_PTCTL;
            st_r.rdy     <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign hreadyout  = st_r.rdy;
    assign hresp      = st_r.wr_pend & 1'b0;
    assign hrdata     = st_r.rdata;
    assign ccp_pin    = st_r.pin;
    assign ccp_int    = st_r.out;
    assign adc_trig   = st_r.adc_trig;
    assign tb_reset   = st_r.tb_rst;
    assign wake_req   = st_r.wake;
    assign event_flag = st_r.flag;

endmodule
`default_nettype wire

// ---- verif/cpwm_checker.sv ----
// port assertions of the compare/pwm unit
`timescale 1ns/1ps
`default_nettype none
module cpwm_checker (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        ccp_pin,
    input wire logic        ccp_int,
    input wire logic        adc_trig,
    input wire logic        tb_reset,
    input wire logic        wake_req,
    input wire logic        event_flag
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic acc;
    assign acc = hsel && htrans[1] && hready;
    property p_trig_flag; adc_trig |-> event_flag; endproperty
    a_trig_flag: assert property (p_trig_flag) else $error("no flag");
    property p_trig_one; adc_trig |=> !adc_trig; endproperty
    a_trig_one: assert property (p_trig_one) else $error("long trig");
    property p_tb_rst; tb_reset |-> $past(adc_trig) && !adc_trig; endproperty
    a_tb_rst: assert property (p_tb_rst) else $error("stray reset");
    property p_pin_int; ccp_pin |-> ccp_int; endproperty
    a_pin_int: assert property (p_pin_int) else $error("pin w/o int");
    property p_wake; wake_req |-> event_flag; endproperty
    a_wake: assert property (p_wake) else $error("wake w/o flag");
    property p_clr0;
        acc && hwrite && haddr[7:0] == 8'h00 ##1 hwdata[7:0] == 8'h00
            |=> !ccp_int && !ccp_pin;
    endproperty
    a_clr0: assert property (p_clr0) else $error("latch not low");
    property p_rd_idle; !(acc && !hwrite) |=> hrdata == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("rdata not 0");
    property p_flag_clr;
        $fell(event_flag) |-> $past(acc, 2) && $past(hwrite, 2);
    endproperty
    a_flag_clr: assert property (p_flag_clr) else $error("flag lost");
endmodule
bind cpwm_unit cpwm_checker i_chk (
    .clock, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
    .hrdata, .ccp_pin, .ccp_int, .adc_trig, .tb_reset, .wake_req,
    .event_flag
);
`default_nettype wire

// ---- verif/cpwm_timebase.sv ----
// compare timebase model feeding the unit's count input
`timescale 1ns/1ps
`default_nettype none
module cpwm_timebase (
    input  wire logic        clock,
    input  wire logic        run,
    input  wire logic        tb_reset,
    output logic      [15:0] tb_count
);
    logic [1:0] pre_r;
    // one step per four clocks, synchronous to the unit
    always_ff @(posedge clock) begin
        if (!run || tb_reset) begin
            pre_r    <= 2'h0;
            tb_count <= 16'h0;
        end else begin
            pre_r <= pre_r + 2'h1;
            if (pre_r == 2'h3) begin
                tb_count <= tb_count + 16'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- verif/tb.sv ----
// bench of the compare/pwm unit
`timescale 1ns/1ps
`default_nettype none
module tb import cpwm_pkg::*;;
    logic        clock = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic        run = 1'b0, rd_dp = 1'b0, hreadyout, ccp_pin, ccp_int;
    logic        adc_trig, tb_reset, wake_req, event_flag;
    logic        cap_in = 1'b0;
    logic [5:0]  pin_exp = 6'b110100, rst_exp = 6'b101000;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, hi;
    logic [15:0] tb_count;
    logic [16:0] seed = 17'h154a1;
    logic [7:0]  v, q[$], dty[3] = '{8'h00, 8'h03, 8'h08};
    cpwm_mode_e  md[6] = '{CPWM_CMP_PULSE, CPWM_CMP_CLR, CPWM_CMP_SET,
                           CPWM_CMP_TGL_RST, CPWM_CMP_TGL, CPWM_CMP_TRIG};
    int          n_fail = 0, n_tests = 0;
    always #20 clock = ~clock;
    cpwm_unit i_dut (
        .clock, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hreadyout, .hresp(), .hrdata,
        .tb_count, .cap_in, .ccp_pin, .ccp_int, .adc_trig,
        .tb_reset, .wake_req, .event_flag
    );
    cpwm_timebase i_tbase (.clock, .run, .tb_reset, .tb_count);
    function automatic logic [16:0] lfsr(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction
    task automatic chk(input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, d);
        @(posedge clock);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, w ? d : 8'h00};
        do @(posedge clock); while (hreadyout !== 1'b1);
    endtask
    task automatic wr(input logic [7:0] a, d);
        xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, e);
        q.push_back(e);
        xfer(1'b0, a, 8'h00);
    endtask
    // read data compared in its data phase
    always @(posedge clock) begin
        if (rd_dp) begin
            chk(hrdata, {24'h0, q.pop_front()});
        end
        rd_dp <= hsel && htrans[1] && !hwrite && hreadyout === 1'b1;
    end
    task automatic results;
        $display("tests %0d fails %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        n_fail++;
        results;
    end
    initial begin
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        rd(8'h00, 8'h00);
        rd(8'h0c, 8'hff);
        rd(8'h1c, 8'h00);
        wr(8'h18, 8'h03);
        for (int m = 0; m < 6; m++) begin
            seed = lfsr(seed);
            v = {2'h0, seed[5:0]} + 8'h08;
            wr(8'h04, v);
            wr(8'h00, {4'hc, md[m]});
            run <= 1'b1;
            for (int i = 0; i < 400 && event_flag !== 1'b1; i++) begin
                @(posedge clock);
            end
            repeat (8) @(posedge clock);
            chk1(event_flag, 1'b1);
            chk1(ccp_pin, pin_exp[m]);
            chk1(tb_count < {8'h0, v}, rst_exp[m]);
            chk1(wake_req, 1'b1);
            run <= 1'b0;
            rd(8'h14, 8'h01);
            wr(8'h14, 8'h01);
            rd(8'h14, 8'h00);
        end
        rd(8'h00, 8'heb);
        wr(8'h00, 8'h00);
        @(posedge clock);
        chk1(ccp_int, 1'b0);
        seed = lfsr(seed);
        v = {2'h0, seed[5:0]} + 8'h08;
        wr(8'h04, v);
        wr(8'h00, 8'hcb);
        @(posedge clock);
        run <= 1'b1;
        // write lands on the edge that raises the trigger; new value far off
        repeat (4 * v - 2) @(posedge clock);
        wr(8'h04, v + 8'h40);
        repeat (8) @(posedge clock);
        chk1(tb_count < {8'h0, v}, 1'b0);
        chk1(event_flag, 1'b1);
        run <= 1'b0;
        wr(8'h0c, 8'h01);
        wr(8'h10, 8'h80);
        rd(8'h10, 8'h80);
        wr(8'h00, 8'hcc);
        for (int d = 0; d < 3; d++) begin
            wr(8'h04, dty[d]);
            repeat (16) @(posedge clock);
            hi = 32'h0;
            repeat (32) begin
                @(posedge clock);
                hi += {31'h0, ccp_pin};
            end
            chk(hi, {22'h0, dty[d], 2'h0});
        end
        rd(8'h14, 8'h01);
        // capture of the count on a rising capture input
        wr(8'h00, 8'hc5);
        wr(8'h14, 8'h01);
        rd(8'h14, 8'h00);
        @(posedge clock);
        run <= 1'b1;
        repeat (4 * v) @(posedge clock);
        cap_in <= 1'b1;
        repeat (8) @(posedge clock);
        run    <= 1'b0;
        cap_in <= 1'b0;
        rd(8'h04, v);
        rd(8'h14, 8'h01);
        results;
    end
endmodule
`default_nettype wire
